// ---- design/clk_div_regs.vh ----
// Register offsets, fields, reset values and timing constants of the system clock divider.
// What this block does
// - Divide select 00,01,10,11 gives system clock at 1/1,1/2,1/4,1/8.
// - Ratio changes at run time and affects internal and output clock alike, except at 1/1 where the output holds high.
// - Prescaler chain divides system clock by 2 up to 4096.
// - Duty adjustment corrects oscillator clock when it is 5 MHz or faster.
// - Divide register resets on reset and hardware standby, holds in software standby.
// - Bits 7 to 2 read as one and ignore writes.
// - System clock feeds prescalers and, at 1/2, 1/4 and 1/8, drives the clock output pin; at 1/1 the pin holds high.
// - Clock output pin driven when disable bit is 0, off when 1.
// - Timed functions count system clock periods, scaling with the ratio.
`ifndef CLK_DIV_REGS_VH
`define CLK_DIV_REGS_VH
`define DIVCTL_OFFSET 16'hff5d
`define DIVCTL_ADDR 32'h0003fd74
`define MODSTBY_OFFSET 16'hff5e
`define MODSTBY_ADDR 32'h0003fd78
`define DIVCTL_RESET 8'hfc
`define DIVCTL_RO_MASK 8'hfc
`define MODSTBY_RESET 8'h40
`define MODSTBY_RO_MASK 8'h40
`define CLKOUT_DIS_BIT 7
`define PRESCALE_WIDTH 12
`define DUTY_MIN_MHZ 5
`define SETTLE_US 500
`endif

// ---- design/ratio_divider.v ----
// Divides the duty-adjusted clock enable train by 1, 2, 4 or 8 with boundary-aligned changes.
`timescale 1ns/1ps
module ratio_divider (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire [1:0] ratioSel,
  output reg sysTick
);
  reg [2:0] cnt_q;
  reg [1:0] active_q;
  wire [2:0] lastCount;
  assign lastCount = (3'h1 << active_q) - 3'h1;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      active_q <= 2'h0;
      sysTick <= 1'b0;
    end else if (clkEn) begin
      if (cnt_q >= lastCount) begin
        cnt_q <= 3'h0;
        sysTick <= 1'b1;
        active_q <= ratioSel;
      end else begin
        cnt_q <= cnt_q + 3'h1;
        sysTick <= 1'b0;
      end
    end
  end
endmodule

// ---- design/prescaler_chain.v ----
// Prescaler producing system clock divided by 2 up to 4096 as enable ticks.
`timescale 1ns/1ps
`include "clk_div_regs.vh"
module prescaler_chain #(
  parameter WIDTH = `PRESCALE_WIDTH
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire sysTick,
  output wire [WIDTH-1:0] taps
);
  reg [WIDTH-1:0] cnt_q;
  reg [WIDTH-1:0] prev_q;
  genvar i;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
    end else if (clkEn && sysTick) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      prev_q <= cnt_q;
    end
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_tap
      assign taps[i] = sysTick & clkEn & cnt_q[i] & ~prev_q[i];
    end
  endgenerate
endmodule

// ---- design/system_clock_divider.v ----
// Top of the system clock divider with AHB-Lite registers, duty stage and clock output.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "clk_div_regs.vh"
module system_clock_divider #(
  parameter PRESCALE_WIDTH = `PRESCALE_WIDTH
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire hwStandby,
  input wire swStandby,
  input wire oscFast,
  input wire extClkIn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg sysTick,
  output reg [PRESCALE_WIDTH-1:0] moduleTicks,
  output reg clkOut,
  output reg clkOutEn
);
  reg [7:0] divCtl_q;
  reg [7:0] modStby_q;
  reg wrPend_q;
  reg [31:0] wrAddr_q;
  reg ext1_q;
  reg ext2_q;
  reg ext3_q;
  reg hws1_q;
  reg hws2_q;
  reg fast1_q;
  reg fast2_q;
  reg dutyPh_q;
  reg dutyEn;
  wire divTick;
  wire [PRESCALE_WIDTH-1:0] taps;
  wire addrPhase;
  wire initNow;

  function isDivCtl;
    input [31:0] addr;
    begin
      isDivCtl = (addr == `DIVCTL_ADDR);
    end
  endfunction

  function isModStby;
    input [31:0] addr;
    begin
      isModStby = (addr == `MODSTBY_ADDR);
    end
  endfunction

  assign addrPhase = hsel & hready & htrans[1];
  assign initNow = ~rst_n | hws2_q;

  // Synchronise the external clock and the hardware standby and speed pins.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      ext3_q <= 1'b0;
      hws1_q <= 1'b0;
      hws2_q <= 1'b0;
      fast1_q <= 1'b0;
      fast2_q <= 1'b0;
    end else if (clkEn) begin
      ext1_q <= extClkIn;
      ext2_q <= ext1_q;
      ext3_q <= ext2_q;
      hws1_q <= hwStandby;
      hws2_q <= hws1_q;
      fast1_q <= oscFast;
      fast2_q <= fast1_q;
    end
  end

  // Duty adjustment turns each source rise into a single tick while fast2_q is set, and every second rise while it is clear.
  always @* begin
    if (fast2_q) begin
      dutyEn = ext2_q & ~ext3_q;
    end else begin
      dutyEn = ext2_q & ~ext3_q & ~dutyPh_q;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      dutyPh_q <= 1'b0;
    end else if (clkEn && ext2_q && !ext3_q) begin
      dutyPh_q <= fast2_q ? 1'b0 : ~dutyPh_q;
    end
  end

  ratio_divider u_div (
    .core_clk(core_clk),
    .rst_n(rst_n & ~hws2_q),
    .clkEn(clkEn & dutyEn),
    .ratioSel(divCtl_q[1:0]),
    .sysTick(divTick)
  );

  prescaler_chain #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_pre (
    .core_clk(core_clk),
    .rst_n(rst_n & ~hws2_q),
    .clkEn(clkEn),
    .sysTick(divTick & dutyEn),
    .taps(taps)
  );

  // Register bus slave with zero wait states.
  always @(posedge core_clk) begin
    if (initNow) begin
      divCtl_q <= `DIVCTL_RESET;
      modStby_q <= `MODSTBY_RESET;
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h00000000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr;
      end
      if (wrPend_q && isDivCtl(wrAddr_q)) begin
        divCtl_q <= hwdata[7:0] | `DIVCTL_RO_MASK;
      end
      if (wrPend_q && isModStby(wrAddr_q)) begin
        modStby_q <= hwdata[7:0] | `MODSTBY_RO_MASK;
      end
      if (addrPhase && !hwrite && isDivCtl(haddr)) begin
        hrdata <= {24'h000000, divCtl_q};
      end else if (addrPhase && !hwrite && isModStby(haddr)) begin
        hrdata <= {24'h000000, modStby_q};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // Clock outputs; swStandby zeroes sysTick and moduleTicks but leaves divCtl_q and modStby_q untouched.
  always @(posedge core_clk) begin
    if (initNow) begin
      sysTick <= 1'b0;
      moduleTicks <= {PRESCALE_WIDTH{1'b0}};
      clkOut <= 1'b0;
      clkOutEn <= 1'b0;
    end else if (clkEn) begin
      sysTick <= divTick & dutyEn & ~swStandby;
      moduleTicks <= swStandby ? {PRESCALE_WIDTH{1'b0}} : taps;
      if (divTick & dutyEn) begin
        clkOut <= 1'b1;
      end else if (dutyEn) begin
        clkOut <= 1'b0;
      end
      clkOutEn <= ~modStby_q[`CLKOUT_DIS_BIT];
    end
  end
endmodule

// ---- tb/clkdiv_properties.sv ----
// Port assertions for the system clock divider.
`timescale 1ns/1ps
module clkdiv_properties #(parameter W = 12) (
  input wire core_clk,
  input wire rst_n,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire sysTick,
  input wire [W-1:0] moduleTicks
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence q3(b); !b [*3]; endsequence
  sequence q7(b); !b [*7]; endsequence
  AST_READY: assert property (hreadyout) else $error("ready low");
  AST_OKAY: assert property (!hresp) else $error("bad response");
  AST_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_TICK: assert property (sysTick |=> !sysTick) else $error("long tick");
  AST_HALF: assert property (moduleTicks[0] |=> q3(moduleTicks[0])) else $error("div2 gap");
  AST_QUARTER: assert property (moduleTicks[1] |=> q7(moduleTicks[1])) else $error("div4 gap");
  AST_EIGHTH: assert property (moduleTicks[2] |=> q7(moduleTicks[2])) else $error("div8 gap");
  AST_TOP: assert property (moduleTicks[W-1] |=> q7(moduleTicks[W-1])) else $error("top gap");
endmodule

// ---- tb/ext_clk_model.sv ----
// External clock source feeding the oscillator input.
`timescale 1ns/1ps
module ext_clk_model (output logic extClkIn = 1'b0);
  initial #7 forever #50 extClkIn = ~extClkIn;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the system clock divider.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, rst_n = 0, clkEn = 1, hsel = 1, hwStandby = 0, swStandby = 0, oscFast = 1, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  wire [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sysTick, clkOut, clkOutEn, extClkIn, hready = hreadyout;
  wire [11:0] moduleTicks;
  int miscompares = 0, comparisons = 0, cyc = 0, n;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (cyc++ == 80000) wrap_up(1);
  ext_clk_model u_src (.*);
  system_clock_divider u_dut (.*);
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    miscompares += (s !== e);
    if (s !== e) $display("ERROR %s expected %h seen %h", nm, e, s);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic gap(input int k);
    repeat (3) begin
      n = 0;
      do @(posedge core_clk) n++; while ((k ? moduleTicks[k-1] : sysTick) !== 1'b1);
    end
  endtask
  task automatic regs;
    bus(0, 32'h3fd74, 0);
    chk("divctl", 32'hfc, r);
    bus(1, 32'h3fd74, 32'h1);
    bus(0, 32'h3fd74, 0);
    chk("divctl", 32'hfd, r);
    bus(0, 32'h3fd7c, 0);
    chk("unmapped", 32'h0, r);
  endtask
  task automatic outputs;
    bus(0, 32'h3fd78, 0);
    chk("modstby", 32'h40, r);
    chk("clkOutEn", 32'h1, clkOutEn);
    bus(1, 32'h3fd74, 32'h1);
    gap(0);
    chk("clkOutHigh", 32'h1, clkOut);
    repeat (6) @(posedge core_clk);
    chk("clkOutLow", 32'h0, clkOut);
    bus(1, 32'h3fd74, 32'h0);
    oscFast <= 1'b0;
    gap(0);
    chk("slowgap", 32'h8, 32'(n));
    oscFast <= 1'b1;
    swStandby <= 1'b1;
    repeat (2) @(posedge core_clk);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      n += sysTick;
    end
    chk("stbyTicks", 32'h0, 32'(n));
    swStandby <= 1'b0;
    clkEn <= 1'b0;
    repeat (2) @(posedge core_clk);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      n += sysTick;
    end
    chk("frozenTicks", 32'h0, 32'(n));
    clkEn <= 1'b1;
    gap(0);
    chk("sysgapAgain", 32'h4, 32'(n));
  endtask
  task automatic rerun;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(0, 32'h3fd74, 0);
    chk("divctlReset", 32'hfc, r);
    bus(0, 32'h3fd78, 0);
    chk("modstbyReset", 32'h40, r);
  endtask
  task automatic ratio;
    for (int s = 0; s < 4; s++) begin
      bus(1, 32'h3fd74, 32'(s));
      gap(0);
      chk("sysgap", 32'h4 << s, 32'(n));
    end
    bus(1, 32'h3fd74, 32'h0);
    gap(12);
    chk("div4096", 32'h4000, 32'(n));
  endtask
  task automatic standby;
    bus(1, 32'h3fd78, 32'h80);
    bus(1, 32'h3fd74, 32'h3);
    chk("clkOutEn", 32'h0, clkOutEn);
    swStandby <= 1'b1;
    bus(0, 32'h3fd74, 0);
    chk("divctl", 32'hff, r);
    hwStandby <= 1'b1;
    repeat (4) @(posedge core_clk);
    hwStandby <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(0, 32'h3fd74, 0);
    chk("divctl", 32'hfc, r);
  endtask
  task automatic wrap_up(input int e);
    miscompares += e;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    regs();
    outputs();
    ratio();
    standby();
    rerun();
    wrap_up(0);
  end
endmodule
bind system_clock_divider clkdiv_properties #(.W(PRESCALE_WIDTH)) u_props (.*);
